// file: scalar_issue_pkg.sv
// shared constants and carriers for the scalar shift / fp issue block
package scalar_issue_pkg;

	// opcode numbers, octal, top seven bits of the parcel
	localparam logic [6:0] OP_DSHL    = 7'h4A; // 112
	localparam logic [6:0] OP_DSHR    = 7'h4B; // 113
	localparam logic [6:0] OP_MASKCP  = 7'h4C; // 114
	localparam logic [6:0] OP_RTCCP   = 7'h4D; // 115
	localparam logic [6:0] OP_IMMPOS  = 7'h4E; // 116
	localparam logic [6:0] OP_IMMNEG  = 7'h4F; // 117
	localparam logic [6:0] OP_FADD    = 7'h50; // 120
	localparam logic [6:0] OP_FSUB    = 7'h51; // 121
	localparam logic [6:0] OP_FIX     = 7'h52; // 122
	localparam logic [6:0] OP_FLT     = 7'h53; // 123
	localparam logic [6:0] OP_FMUL_A  = 7'h54; // 124
	localparam logic [6:0] OP_FMUL_B  = 7'h55; // 125
	localparam logic [6:0] OP_MASKLD  = 7'h1C; // 034
	localparam logic [6:0] OP_RTCLD   = 7'h1D; // 035

	// shift count limits
	localparam logic [31:0] SHIFT_WHOLE = 32'h0000_0040; // 64
	localparam logic [31:0] SHIFT_LIMIT = 32'h0000_0080; // 128

	// issue timing, in phases after issue (two phases per clock)
	localparam int PH_PER_CLK      = 2;
	localparam int PH_NEXT_ISSUE   = 2;
	localparam int PH_SHIFT_DONE   = 15;
	localparam int PH_COPY_DONE    = 15;
	localparam int PH_IMM_DONE     = 7;
	localparam int PH_FADD_DONE    = 29;
	localparam int PH_FMUL_DONE    = 31;
	localparam int PH_LOAD_HOLD    = 4;

	// phase counts to clock cycles, rounded up; the load hold count is truncated
	localparam int CYC_SHIFT = (PH_SHIFT_DONE + PH_PER_CLK - 1) / PH_PER_CLK;
	localparam int CYC_COPY  = (PH_COPY_DONE + PH_PER_CLK - 1) / PH_PER_CLK;
	localparam int CYC_IMM   = (PH_IMM_DONE + PH_PER_CLK - 1) / PH_PER_CLK;
	localparam int CYC_FADD  = (PH_FADD_DONE + PH_PER_CLK - 1) / PH_PER_CLK;
	localparam int CYC_FMUL  = (PH_FMUL_DONE + PH_PER_CLK - 1) / PH_PER_CLK;
	localparam int CYC_HOLD  = PH_LOAD_HOLD / PH_PER_CLK;

	// one instruction offered for issue
	typedef struct packed {
		logic [6:0]  opcode;
		logic [2:0]  dest;
		logic [63:0] scalar_src_a;
		logic [63:0] scalar_src_b;
		logic [63:0] dest_old;
		logic [31:0] addr_reg_count_src;
		logic [5:0]  immediate_six_bit_field;
	} issue_req_s;

	// resource readiness from issue control
	typedef struct packed {
		logic count_free;
		logic operands_free;
		logic dest_path_free;
		logic mask_free;
		logic rtc_free;
		logic vec_logic_free;
		logic fadd_free;
		logic fmul_free;
	} res_free_s;

	// write back to the scalar register file
	typedef struct packed {
		logic        valid;
		logic [2:0]  dest;
		logic [63:0] data;
	} wb_s;

	// result unit selector
	typedef enum logic [2:0] {
		UNIT_SHIFT = 3'b000,
		UNIT_COPY  = 3'b001,
		UNIT_IMM   = 3'b010,
		UNIT_FADD  = 3'b011,
		UNIT_FMUL  = 3'b100,
		UNIT_NONE  = 3'b111
	} unit_e;

endpackage

// file: scalar_shift_fp_issue.sv
// scalar double shift, copy, immediate and fp add/multiply issue block

// ----------------------------------------
// Summary of operation
// ----------------------------------------
module scalar_shift_fp_issue #(
	parameter int FP_LAT = 4
) (
	// clock, reset, enable
	input  wire logic                         clk_sys,
	input  wire logic                         reset,
	input  wire logic                         clk_en,
	// instruction offered by issue control
	input  wire logic                         req_valid,
	input  wire scalar_issue_pkg::issue_req_s req,
	input  wire scalar_issue_pkg::res_free_s  res_free,
	input  wire logic                         prev_was_load,
	// live mask and counter values
	input  wire logic [63:0]                  lane_mask_register,
	input  wire logic [63:0]                  rtc_value,
	// results of the external fp units
	input  wire logic [63:0]                  fadd_result,
	input  wire logic [63:0]                  fmul_result,
	// issue handshake
	output logic                              issue_ack,
	output logic                              dest_busy,
	output logic [2:0]                        busy_dest,
	// fp unit launches
	output logic                              fadd_start,
	output logic [1:0]                        fadd_op,
	output logic [63:0]                       fadd_opa,
	output logic [63:0]                       fadd_opb,
	output logic                              fmul_start,
	// scalar register write back
	output scalar_issue_pkg::wb_s             wb
);

	// ----------------------------------------
	// parameter check
	// ----------------------------------------
	initial begin
		if (FP_LAT < 1 || FP_LAT > scalar_issue_pkg::CYC_FADD - 1)
			$error("FP_LAT out of range");
	end

	// ----------------------------------------
	// decode
	// ----------------------------------------
	wire logic [6:0] op = req.opcode;
	wire logic is_dshl  = (op == scalar_issue_pkg::OP_DSHL);
	wire logic is_dshr  = (op == scalar_issue_pkg::OP_DSHR);
	wire logic is_shift = is_dshl | is_dshr;
	wire logic is_mask  = (op == scalar_issue_pkg::OP_MASKCP);
	wire logic is_rtc   = (op == scalar_issue_pkg::OP_RTCCP);
	wire logic is_imm_p = (op == scalar_issue_pkg::OP_IMMPOS);
	wire logic is_imm_n = (op == scalar_issue_pkg::OP_IMMNEG);
	wire logic is_imm   = is_imm_p | is_imm_n;
	wire logic is_fadd  = (op == scalar_issue_pkg::OP_FADD)
		| (op == scalar_issue_pkg::OP_FSUB)
		| (op == scalar_issue_pkg::OP_FIX)
		| (op == scalar_issue_pkg::OP_FLT);
	wire logic is_fmul  = (op == scalar_issue_pkg::OP_FMUL_A)
		| (op == scalar_issue_pkg::OP_FMUL_B);
	wire logic is_ours  = is_shift | is_mask | is_rtc | is_imm
		| is_fadd | is_fmul;

	// ----------------------------------------
	// load hold and busy state
	// ----------------------------------------
	logic        last_mask_ld_r;
	logic        last_rtc_ld_r;
	logic [1:0]  hold_cnt_r;
	logic [1:0]  hold_cnt_nxt;
	logic [4:0]  busy_cnt_r;
	logic [4:0]  busy_cnt_nxt;
	logic [4:0]  fp_cnt_r;
	logic [4:0]  fp_cnt_nxt;
	scalar_issue_pkg::unit_e unit_r;
	scalar_issue_pkg::unit_e unit_nxt;
	logic [63:0] res_r;
	logic [2:0]  dest_r;

	// a copy seen for issue with prev_was_load set is marked as following a load
	wire logic see_mask_ld = req_valid & prev_was_load
		& (op == scalar_issue_pkg::OP_MASKCP);
	wire logic see_rtc_ld  = req_valid & prev_was_load
		& (op == scalar_issue_pkg::OP_RTCCP);
	wire logic load_hold   = (see_mask_ld | see_rtc_ld)
		& (hold_cnt_r == 2'h0) & ~(last_mask_ld_r | last_rtc_ld_r);
	wire logic holding     = (hold_cnt_r != 2'h0) | load_hold;

	// ----------------------------------------
	// issue conditions
	// ----------------------------------------
	wire logic path_idle = (busy_cnt_r == 5'h00);
	wire logic ok_shift  = res_free.count_free & res_free.operands_free
		& res_free.dest_path_free;
	wire logic ok_mask   = res_free.mask_free & res_free.vec_logic_free
		& res_free.dest_path_free;
	wire logic ok_rtc    = res_free.rtc_free & res_free.vec_logic_free
		& res_free.dest_path_free;
	wire logic ok_imm    = res_free.operands_free
		& res_free.dest_path_free;
	wire logic ok_fadd   = res_free.operands_free & res_free.fadd_free
		& res_free.dest_path_free;
	wire logic ok_fmul   = res_free.operands_free & res_free.fmul_free
		& res_free.dest_path_free;
	wire logic cond_ok   = (is_shift & ok_shift) | (is_mask & ok_mask)
		| (is_rtc & ok_rtc) | (is_imm & ok_imm) | (is_fadd & ok_fadd)
		| (is_fmul & ok_fmul);
	wire logic do_issue  = clk_en & req_valid & is_ours & cond_ok
		& path_idle & ~holding;

	// ----------------------------------------
	// double shift datapath
	// ----------------------------------------
	wire logic [31:0]  cnt   = req.addr_reg_count_src;
	wire logic         big   = (cnt > scalar_issue_pkg::SHIFT_LIMIT);
	wire logic [7:0]   amt   = cnt[7:0];
	// left: destination high, second operand low
	wire logic [127:0] cat_l = {req.dest_old, req.scalar_src_a};
	// right: second operand high, destination low
	wire logic [127:0] cat_r = {req.scalar_src_a, req.dest_old};
	// logical shifts fill zeros; 128 drains all bits
	wire logic [127:0] sh_l  = cat_l << amt;
	wire logic [127:0] sh_r  = cat_r >> amt;
	// window at the destination's original place; 0 keeps it, 64 gives a
	wire logic [63:0]  sh_res = big ? 64'h0 :
		(is_dshl ? sh_l[127:64] : sh_r[63:0]);

	// ----------------------------------------
	// copy and immediate datapath
	// ----------------------------------------
	wire logic [63:0] copy_res = is_mask ? lane_mask_register
		: rtc_value;
	wire logic [63:0] imm_res  = is_imm_n
		? {58'h3FF_FFFF_FFFF_FFFF, req.immediate_six_bit_field}
		: {58'h0, req.immediate_six_bit_field};

	// fp add op code: 0 sum, 1 difference, 2 fix, 3 float
	wire logic [1:0] fop = op[1:0];

	// ----------------------------------------
	// next state
	// ----------------------------------------
	always_comb begin
		hold_cnt_nxt = hold_cnt_r;
		if (load_hold)
			hold_cnt_nxt = 2'(scalar_issue_pkg::CYC_HOLD - 1);
		else if (hold_cnt_r != 2'h0)
			hold_cnt_nxt = hold_cnt_r - 2'h1;
		busy_cnt_nxt = (busy_cnt_r != 5'h00) ? busy_cnt_r - 5'h01 : 5'h00;
		fp_cnt_nxt   = (fp_cnt_r != 5'h00) ? fp_cnt_r - 5'h01 : 5'h00;
		unit_nxt     = (busy_cnt_r == 5'h01) ? scalar_issue_pkg::UNIT_NONE
			: unit_r;
		if (do_issue) begin
			// only fp results land late; others keep their issue value
			fp_cnt_nxt = (is_fadd | is_fmul) ? 5'(FP_LAT) : 5'h00;
			case (1'b1)
				is_shift: begin
					busy_cnt_nxt = 5'(scalar_issue_pkg::CYC_SHIFT);
					unit_nxt     = scalar_issue_pkg::UNIT_SHIFT;
				end
				is_imm: begin
					busy_cnt_nxt = 5'(scalar_issue_pkg::CYC_IMM);
					unit_nxt     = scalar_issue_pkg::UNIT_IMM;
				end
				is_fadd: begin
					busy_cnt_nxt = 5'(scalar_issue_pkg::CYC_FADD);
					unit_nxt     = scalar_issue_pkg::UNIT_FADD;
				end
				is_fmul: begin
					busy_cnt_nxt = 5'(scalar_issue_pkg::CYC_FMUL);
					unit_nxt     = scalar_issue_pkg::UNIT_FMUL;
				end
				default: begin
					busy_cnt_nxt = 5'(scalar_issue_pkg::CYC_COPY);
					unit_nxt     = scalar_issue_pkg::UNIT_COPY;
				end
			endcase
		end
	end

	// selected result at issue
	wire logic [63:0] issue_res = is_shift ? sh_res
		: is_imm ? imm_res : copy_res;

	// ----------------------------------------
	// state registers
	// ----------------------------------------
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			hold_cnt_r     <= 2'h0;
			last_mask_ld_r <= 1'b0;
			last_rtc_ld_r  <= 1'b0;
			busy_cnt_r     <= 5'h00;
			fp_cnt_r       <= 5'h00;
			unit_r         <= scalar_issue_pkg::UNIT_NONE;
			res_r          <= 64'h0;
			dest_r         <= 3'h0;
		end else if (clk_en) begin
			hold_cnt_r     <= hold_cnt_nxt;
			// served hold is remembered until the copy issues or the request is dropped
			last_mask_ld_r <= (load_hold & see_mask_ld)
				| (last_mask_ld_r & req_valid & ~do_issue);
			last_rtc_ld_r  <= (load_hold & see_rtc_ld)
				| (last_rtc_ld_r & req_valid & ~do_issue);
			busy_cnt_r     <= busy_cnt_nxt;
			fp_cnt_r       <= fp_cnt_nxt;
			unit_r         <= unit_nxt;
			if (do_issue) begin
				res_r  <= issue_res;
				dest_r <= req.dest;
			end else if (fp_cnt_r == 5'h01) begin
				res_r <= (unit_r == scalar_issue_pkg::UNIT_FMUL)
					? fmul_result : fadd_result;
			end
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	// fix result is sign extended from the 32-bit low part
	wire logic fix_pend = (unit_r == scalar_issue_pkg::UNIT_FADD);
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			issue_ack  <= 1'b0;
			dest_busy  <= 1'b0;
			busy_dest  <= 3'h0;
			fadd_start <= 1'b0;
			fadd_op    <= 2'h0;
			fadd_opa   <= 64'h0;
			fadd_opb   <= 64'h0;
			fmul_start <= 1'b0;
			wb         <= '0;
		end else if (clk_en) begin
			issue_ack  <= do_issue;
			dest_busy  <= busy_cnt_nxt != 5'h00;
			busy_dest  <= do_issue ? req.dest : busy_dest;
			fadd_start <= do_issue & is_fadd;
			fmul_start <= do_issue & is_fmul;
			if (do_issue & is_fadd) begin
				fadd_op  <= fop;
				// sum and difference: a then b, minuend a
				fadd_opa <= (fop[1]) ? req.scalar_src_b
					: req.scalar_src_a;
				fadd_opb <= (fop[1]) ? 64'h0 : req.scalar_src_b;
			end
			wb.valid <= (busy_cnt_r == 5'h01);
			wb.dest  <= dest_r;
			wb.data  <= (fix_pend & fadd_op == 2'h2)
				? {{32{res_r[31]}}, res_r[31:0]} : res_r;
		end
	end

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (reset);

	sequence shift_issue_s;
		do_issue & is_shift;
	endsequence
	sequence busy_run_s;
		dest_busy [*7];
	endsequence

	shift_zero_big_a: assert property (is_shift & big |-> sh_res == 64'h0)
		else $error("big shift not zero");
	shift_whole_a: assert property (is_dshr & cnt == 32'h40
		|-> sh_res == req.scalar_src_a)
		else $error("count 64 wrong");
	shift_none_a: assert property (is_shift & cnt == 32'h0
		|-> sh_res == req.dest_old)
		else $error("count 0 wrong");
	shift_busy_a: assert property (shift_issue_s |=> busy_run_s)
		else $error("shift busy short");
	ack_follow_a: assert property (do_issue |=> issue_ack)
		else $error("ack missing");
	mask_copy_a: assert property (do_issue & is_mask
		|-> issue_res == lane_mask_register)
		else $error("mask copy wrong");
	load_hold_a: assert property (load_hold |-> ~do_issue ##1 ~do_issue)
		else $error("load hold broken");
	imm_neg_a: assert property (is_imm_n
		|-> imm_res[63:6] == 58'h3FF_FFFF_FFFF_FFFF)
		else $error("neg imm wrong");
	fadd_busy_a: assert property (do_issue & is_fadd
		|=> (dest_busy [*8]) ##7 dest_busy)
		else $error("fadd busy short");

	// pulses, launches and field checks
	sequence wb_end_s;
		~wb.valid;
	endsequence

	count_whole_a: assert property (is_shift & (cnt[31:8] != 24'h0)
		|-> sh_res == 64'h0)
		else $error("upper count bits ignored");
	busy_no_issue_a: assert property (dest_busy |-> ~do_issue)
		else $error("issue while busy");
	ack_pulse_a: assert property (issue_ack & clk_en |=> ~issue_ack)
		else $error("ack longer than one cycle");
	wb_pulse_a: assert property (wb.valid & clk_en |=> wb_end_s)
		else $error("write back longer than one cycle");
	rtc_copy_a: assert property (do_issue & is_rtc
		|-> issue_res == rtc_value)
		else $error("counter copy wrong");
	imm_pos_a: assert property (is_imm_p
		|-> imm_res == {58'h0, req.immediate_six_bit_field})
		else $error("pos imm wrong");
	imm_low_a: assert property (is_imm_n
		|-> imm_res[5:0] == req.immediate_six_bit_field)
		else $error("neg imm low bits wrong");
	fsub_order_a: assert property (do_issue & is_fadd & (fop == 2'h1)
		|=> fadd_opa == $past(req.scalar_src_a))
		else $error("minuend not from source a");
	fadd_launch_a: assert property (do_issue & is_fadd
		|=> fadd_start & (fadd_op == $past(fop)))
		else $error("fadd launch wrong");
	fmul_alias_a: assert property (do_issue & is_fmul
		|=> fmul_start & ~fadd_start)
		else $error("multiply alias not launched");

endmodule // scalar_shift_fp_issue

// file: fp_unit_model.sv
// stand-in for the external fp add and multiply units
module fp_unit_model #(
	parameter int FP_LAT = 4
) (
	// clock and reset
	input  wire logic        clk_sys,
	input  wire logic        reset,
	// launches from the block
	input  wire logic        fadd_start,
	input  wire logic [1:0]  fadd_op,
	input  wire logic [63:0] fadd_opa,
	input  wire logic [63:0] fadd_opb,
	input  wire logic        fmul_start,
	// unit results
	output logic [63:0]      fadd_result,
	output logic [63:0]      fmul_result
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [63:0] add_r;
	logic [63:0] mul_r;
	logic [31:0] mul_n_r;
	int          age_a_r;
	int          age_m_r;

	// latch one result per launch, age it every clock
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			add_r   <= 64'h0;
			mul_r   <= 64'h0;
			mul_n_r <= 32'h0;
			age_a_r <= 99;
			age_m_r <= 99;
		end else begin
			age_a_r <= fadd_start ? 0 : (age_a_r < 99 ? age_a_r + 1 : 99);
			age_m_r <= fmul_start ? 0 : (age_m_r < 99 ? age_m_r + 1 : 99);
			if (fadd_start) begin
				add_r <= fadd_opa + fadd_opb + {62'h0, fadd_op};
			end
			if (fmul_start) begin
				mul_n_r <= mul_n_r + 32'h1;
				mul_r   <= {32'hA5A5_5A5A, mul_n_r + 32'h1};
			end
		end
	end

	// result valid only around its sample edge, inverted elsewhere
	assign fadd_result = (age_a_r >= FP_LAT - 2 && age_a_r <= FP_LAT) ? add_r : ~add_r;
	assign fmul_result = (age_m_r >= FP_LAT - 2 && age_m_r <= FP_LAT) ? mul_r : ~mul_r;
endmodule // fp_unit_model

// file: scalar_shift_fp_issue_bench.sv
// self-checking bench for the scalar shift / fp issue block
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin n_fail++; \
	$display("MISMATCH %s expected %0h seen %0h", nm, e, g); end end

module scalar_shift_fp_issue_bench;
	timeunit 1ns;
	timeprecision 1ns;
	logic                        clk_sys = 1'b0;
	logic                        reset = 1'b1;
	logic                        clk_en = 1'b1;
	logic                        req_valid = 1'b0;
	logic                        prev_was_load = 1'b0;
	scalar_issue_pkg::issue_req_s req = '0;
	scalar_issue_pkg::res_free_s  res_free = '1;
	logic [63:0]                 lane_mask_register = 64'hF0F0_1234_8000_0001;
	logic [63:0]                 rtc_value = 64'h0123_4567_89AB_CDEF;
	logic [63:0]                 fadd_result, fmul_result, fadd_opa, fadd_opb;
	logic                        issue_ack, dest_busy, fadd_start, fmul_start;
	logic [2:0]                  busy_dest;
	logic [1:0]                  fadd_op;
	scalar_issue_pkg::wb_s       wb;
	int                          n_fail = 0, checked = 0, cyc = 0, n_mul = 0;

	// ----------------------------------------
	// clock, design and unit model
	// ----------------------------------------
	always #5 clk_sys = ~clk_sys;

	scalar_shift_fp_issue u_dut (.clk_sys(clk_sys), .reset(reset),
		.clk_en(clk_en), .req_valid(req_valid), .req(req), .res_free(res_free),
		.prev_was_load(prev_was_load), .lane_mask_register(lane_mask_register),
		.rtc_value(rtc_value), .fadd_result(fadd_result),
		.fmul_result(fmul_result), .issue_ack(issue_ack), .dest_busy(dest_busy),
		.busy_dest(busy_dest), .fadd_start(fadd_start), .fadd_op(fadd_op),
		.fadd_opa(fadd_opa), .fadd_opb(fadd_opb), .fmul_start(fmul_start),
		.wb(wb));

	fp_unit_model u_fp (.clk_sys(clk_sys), .reset(reset),
		.fadd_start(fadd_start), .fadd_op(fadd_op), .fadd_opa(fadd_opa),
		.fadd_opb(fadd_opb), .fmul_start(fmul_start),
		.fadd_result(fadd_result), .fmul_result(fmul_result));

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	// expected double shift window
	function automatic logic [63:0] dsh(input logic lft,
		input logic [63:0] a, input logic [63:0] d, input logic [31:0] n);
		logic [127:0] w;
		w = lft ? ({d, a} << n) : ({a, d} >> n);
		return (n > 32'h0000_0080) ? 64'h0 : (lft ? w[127:64] : w[63:0]);
	endfunction

	// offer one instruction, judge issue delay, write back and busy
	task automatic run(input logic [6:0] op, input logic [63:0] a, b, d,
		input logic [31:0] cnt, input logic [5:0] imm, input logic [2:0] dst,
		input logic [7:0] blk, input int hold, frz, e_iss, e_wb,
		input logic [63:0] e_dat);
		int t_iss;
		int t_wb;
		@(negedge clk_sys);
		req = '{op, dst, a, b, d, cnt, imm};
		res_free = ~blk;
		req_valid = 1'b1;
		t_iss = 0;
		while (issue_ack !== 1'b1 && t_iss < 40) begin
			@(negedge clk_sys);
			t_iss++;
			if (t_iss == hold) res_free = '1;
		end
		req_valid = 1'b0;
		prev_was_load = 1'b0;
		`CHK("issue_delay", e_iss, t_iss)
		`CHK("dest_busy", 1'b1, dest_busy)
		`CHK("busy_dest", dst, busy_dest)
		if (op[6:2] == 5'h14) begin
			`CHK("fadd_start", 1'b1, fadd_start)
			`CHK("fadd_op", op[1:0], fadd_op)
			`CHK("fadd_opa", op[1] ? b : a, fadd_opa)
			`CHK("fadd_opb", op[1] ? 64'h0 : b, fadd_opb)
		end
		if (op[6:1] == 6'h2A) `CHK("fmul_start", 1'b1, fmul_start)
		t_wb = 0;
		while (wb.valid !== 1'b1 && t_wb < 60) begin
			clk_en = (t_wb >= frz);
			@(negedge clk_sys);
			t_wb++;
		end
		clk_en = 1'b1;
		`CHK("wb_delay", e_wb, t_wb)
		`CHK("wb_dest", dst, wb.dest)
		`CHK("wb_data", e_dat, wb.data)
		@(negedge clk_sys);
		`CHK("busy_clear", 1'b0, dest_busy)
	endtask

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	// both shifts over boundary counts, the first three counts of each shift wait on a resource
	task automatic t_shift;
		logic [31:0] cnts [9] = '{32'h0, 32'h1, 32'h3F, 32'h40, 32'h41,
			32'h7F, 32'h80, 32'h81, 32'h8000_0040};
		logic [63:0] a = 64'h8123_4567_89AB_CDEF;
		logic [63:0] d = 64'hF00D_CAFE_1357_9BDF;
		logic [7:0]  blk;
		for (int i = 0; i < 18; i++) begin
			blk = (i % 9 == 0) ? 8'h80 : (i % 9 == 1) ? 8'h40 : (i % 9 == 2) ? 8'h20 : 8'h00;
			run(i < 9 ? scalar_issue_pkg::OP_DSHL : scalar_issue_pkg::OP_DSHR,
				a, 64'h0, d, cnts[i % 9], 6'h0, 3'(i), blk, i % 9 < 3 ? 2 : 0, 0,
				i % 9 < 3 ? 3 : 1, scalar_issue_pkg::CYC_SHIFT,
				dsh(i < 9, a, d, cnts[i % 9]));
		end
		$display("test shift done");
	endtask

	// mask and counter copies, resource waits and load holds
	task automatic t_copy;
		run(scalar_issue_pkg::OP_MASKCP, 64'h1, 64'h2, 64'h3, 32'h0, 6'h0, 3'h1, 8'h04,
			2, 0, 3, scalar_issue_pkg::CYC_COPY, lane_mask_register);
		run(scalar_issue_pkg::OP_MASKCP, 64'h1, 64'h2, 64'h3, 32'h0, 6'h0, 3'h2, 8'h10,
			2, 0, 3, scalar_issue_pkg::CYC_COPY, lane_mask_register);
		prev_was_load = 1'b1;
		run(scalar_issue_pkg::OP_MASKCP, 64'h1, 64'h2, 64'h3, 32'h0, 6'h0, 3'h3, 8'h00,
			0, 0, 1 + scalar_issue_pkg::CYC_HOLD, scalar_issue_pkg::CYC_COPY,
			lane_mask_register);
		run(scalar_issue_pkg::OP_RTCCP, 64'h1, 64'h2, 64'h3, 32'h0, 6'h0, 3'h4, 8'h08,
			2, 0, 3, scalar_issue_pkg::CYC_COPY, rtc_value);
		prev_was_load = 1'b1;
		run(scalar_issue_pkg::OP_RTCCP, 64'h1, 64'h2, 64'h3, 32'h0, 6'h0, 3'h5, 8'h00,
			0, 0, 1 + scalar_issue_pkg::CYC_HOLD, scalar_issue_pkg::CYC_COPY,
			rtc_value);
		$display("test copy done");
	endtask

	// immediates at field bounds, one frozen by the clock enable
	task automatic t_imm;
		run(scalar_issue_pkg::OP_IMMPOS, 64'hF, 64'hF, 64'hF, 32'h0, 6'h3F, 3'h6, 8'h20,
			2, 0, 3, scalar_issue_pkg::CYC_IMM, 64'h3F);
		run(scalar_issue_pkg::OP_IMMNEG, 64'h0, 64'h0, 64'h0, 32'h0, 6'h00, 3'h7, 8'h00,
			0, 0, 1, scalar_issue_pkg::CYC_IMM, 64'hFFFF_FFFF_FFFF_FFC0);
		run(scalar_issue_pkg::OP_IMMNEG, 64'h0, 64'h0, 64'h0, 32'h0, 6'h15, 3'h0, 8'h00,
			0, 5, 1, scalar_issue_pkg::CYC_IMM + 5, 64'hFFFF_FFFF_FFFF_FFD5);
		$display("test immediate done");
	endtask

	// add unit operations and both multiply opcodes
	task automatic t_fp;
		logic [63:0] a = 64'h4000_0000_0000_0100;
		logic [63:0] b = 64'h0000_0000_8000_0010;
		for (int k = 0; k < 4; k++) begin
			run(scalar_issue_pkg::OP_FADD + 7'(k), a, b, 64'h0, 32'h0, 6'h0, 3'(k),
				k == 0 ? 8'h02 : 8'h00, k == 0 ? 2 : 0, 0, k == 0 ? 3 : 1,
				scalar_issue_pkg::CYC_FADD, k == 0 ? a + b : k == 1 ? a + b + 64'h1 :
				k == 2 ? 64'hFFFF_FFFF_8000_0012 : b + 64'h3);
		end
		for (int k = 0; k < 2; k++) begin
			n_mul++;
			run(scalar_issue_pkg::OP_FMUL_A + 7'(k), a, b, 64'h0, 32'h0, 6'h0, 3'h2,
				k == 0 ? 8'h01 : 8'h00, k == 0 ? 2 : 0, 0, k == 0 ? 3 : 1,
				scalar_issue_pkg::CYC_FMUL, {32'hA5A5_5A5A, 32'(n_mul)});
		end
		$display("test fp done");
	endtask

	// opcodes outside the group are never taken
	task automatic t_refuse;
		int acks;
		acks = 0;
		@(negedge clk_sys);
		req_valid = 1'b1;
		for (int k = 0; k < 12; k++) begin
			req.opcode = (k < 6) ? scalar_issue_pkg::OP_MASKLD : 7'h56;
			@(negedge clk_sys);
			if (issue_ack === 1'b1) acks++;
		end
		req_valid = 1'b0;
		`CHK("foreign_ack", 0, acks)
		$display("test refuse done");
	endtask

	// counts and verdict
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	// hang guard
	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 5000) begin
			n_fail++;
			tally_and_finish;
		end
	end

	// main sequence
	initial begin
		repeat (20) @(negedge clk_sys);
		reset = 1'b0;
		t_shift;
		t_copy;
		t_imm;
		t_fp;
		t_refuse;
		tally_and_finish;
	end
endmodule // scalar_shift_fp_issue_bench
